// ### common/adc_ctrl_pkg.sv
// Notes on behaviour
// RULE1: Done flag cleared by writing one or servicing.
// RULE2: Interrupt request needs enable and global enable.
// RULE3: Prescaler codes divide clock by 2..128.
// RULE4: Comparator negative input picked by two-bit field.
// RULE5: Trigger pick bit chooses comparator 0 or 1.
// RULE6: Trigger source ignored unless auto-trigger on.
// RULE7: Selected flag rising edge starts conversion.
// RULE8: Source code zero is continuous conversion; the code runs one conversion per start bit there and does not restart.
// RULE9: Codes one to seven pick listed sources.
// RULE10: Three-bit reference select spans two registers.
// RULE11: Reference change applies after current conversion.
// RULE12: Alignment bit picks left or right result.
// RULE13: Five-bit channel field routes converter input.
// RULE14: Polarity flip only for offset calibration.
// RULE15: Speed bit picks slow or fast conversion.
// RULE16: Path bit picks multiplexer or differential amplifier.
// RULE17: Test bit drives internal reference out pin.
// RULE18: Disable bits switch off pin digital inputs.
// RULE19: Offset enable corrects results with offset registers.
// RULE20: Start bit begins single or first continuous conversion.
// RULE21: Converter enabled while its enable bit set.
// RULE22: Low byte layout follows alignment bit.
// RULE23: Done flag sets when result becomes readable.
`default_nettype none

package adc_ctrl_pkg;

   // ----------------------------------------------------------------
   // Register offsets.
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_DATA_LO   = 8'h78;
   localparam logic [7:0] ADDR_DATA_HI   = 8'h79;
   localparam logic [7:0] ADDR_CSR_A     = 8'h7a;
   localparam logic [7:0] ADDR_CSR_B     = 8'h7b;
   localparam logic [7:0] ADDR_MUX       = 8'h7c;
   localparam logic [7:0] ADDR_CSR_C     = 8'h7d;
   localparam logic [7:0] ADDR_DIS_0     = 8'h7e;
   localparam logic [7:0] ADDR_DIS_1     = 8'h7f;
   localparam logic [7:0] ADDR_OFS_0     = 8'ha3;
   localparam logic [7:0] ADDR_OFS_1     = 8'ha4;
   localparam logic [7:0] ADDR_CSR_D     = 8'had;

   // ----------------------------------------------------------------
   // Field positions and reset values.
   // ----------------------------------------------------------------
   localparam int BIT_CONVERTER_ON = 7;
   localparam int BIT_START        = 6;
   localparam int BIT_AUTO_TRIG    = 5;
   localparam int BIT_DONE         = 4;
   localparam int BIT_IRQ_EN       = 3;
   localparam int BIT_CMP_PICK     = 3;
   localparam int BIT_LEFT_ALIGN   = 5;
   localparam int BIT_REF_MSB      = 6;
   localparam int BIT_OFS_ON       = 7;
   localparam int BIT_POL_FLIP     = 5;
   localparam int BIT_FAST         = 2;
   localparam int BIT_DIFF_PATH    = 1;
   localparam int BIT_REF_TEST     = 0;
   localparam logic [7:0] RST_CSR_A = 8'h05;
   localparam logic [7:0] RST_ZERO  = 8'h00;
   localparam logic [7:0] MASK_CSR_C = 8'hb7;
   localparam logic [7:0] MASK_CSR_D = 8'hf7;

   // ----------------------------------------------------------------
   // Timing: conversion length in converter clocks.
   // ----------------------------------------------------------------
   localparam int CONV_TICKS = 15;

   // Trigger source codes.
   localparam logic [2:0] TRIG_CONTINUOUS = 3'h0;

   // Conversion sequencer states, Gray coded.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONV = 2'b01,
      ST_DONE = 2'b11
   } conv_state_t;

   // Settings handed to the analog core.
   typedef struct packed {
      logic [2:0] reference;
      logic [4:0] channel;
      logic       pol_flip;
      logic       fast;
      logic       diff_path;
      logic       ref_test;
      logic [1:0] cmp0_neg;
      logic [1:0] cmp1_neg;
   } analog_cfg_t;

   // Trigger inputs bundle.
   typedef struct packed {
      logic cmp0;
      logic cmp1;
      logic ext_int0;
      logic t0_match;
      logic t0_ovf;
      logic t1_match_b;
      logic t1_ovf;
      logic t1_capture;
   } trig_in_t;

endpackage : adc_ctrl_pkg

`default_nettype wire

// ### hdl/adc_control_logic.sv
`timescale 1ns/1ps
`default_nettype none

module adc_control_logic
   #(
      parameter int DATA_BITS = 12
   )
   (
      // Clock and reset.
      input  wire logic                      CORE_CLK,
      input  wire logic                      RST,
      // Register port.
      input  wire logic [7:0]                ADDR,
      input  wire logic [7:0]                WDATA,
      input  wire logic                      WR,
      input  wire logic                      RD,
      output logic      [7:0]                RDATA,
      // Interrupt system.
      input  wire logic                      GLOBAL_IRQ_EN,
      input  wire logic                      IRQ_ACK,
      output logic                           IRQ_REQ,
      // Trigger sources, same clock.
      input  wire adc_ctrl_pkg::trig_in_t    TRIG,
      // Analog core.
      output adc_ctrl_pkg::analog_cfg_t      ANA_CFG,
      output logic                           ANA_ENABLE,
      output logic                           ANA_SAMPLE,
      output logic                           ANA_TICK,
      input  wire logic [DATA_BITS-1:0]      ANA_RESULT,
      // Pin digital input disables.
      output logic      [15:0]               PIN_DIG_IN_OFF
   );

   // ----------------------------------------------------------------
   // Registers.
   // ----------------------------------------------------------------
   logic [7:0]  csr_a_q;          // Control and status A.
   logic [7:0]  csr_b_q;          // Control and status B.
   logic [7:0]  mux_q;            // Channel and reference select.
   logic [7:0]  csr_c_q;          // Control and status C.
   logic [7:0]  csr_d_q;          // Control D.
   logic [7:0]  dis0_q;           // Digital input disable 0.
   logic [7:0]  dis1_q;           // Digital input disable 1.
   logic [7:0]  ofs0_q;           // Signed offset 0.
   logic [7:0]  ofs1_q;           // Signed offset 1.
   logic [11:0] result_q;         // Latest corrected result.
   logic [2:0]  ref_q;            // Reference applied to the core.
   logic [6:0]  div_q;            // Prescaler counter.
   logic [3:0]  tick_cnt_q;       // Converter clocks left.
   logic        trig_prev_q;      // Last selected trigger level.
   logic        tick;             // One-cycle converter clock enable.
   logic        trig_sel;         // Selected trigger flag.
   logic        trig_edge;        // Rising edge of selected flag.
   logic        start_req;        // Request to begin a conversion.
   logic        finish;           // Result lands this cycle.
   logic [11:0] corrected;        // Offset-corrected result.
   logic [6:0]  div_limit;        // Terminal count for the prescaler.
   logic        wr_a;             // Write to control A.
   adc_ctrl_pkg::conv_state_t state_q;

   assign wr_a = WR && (ADDR == adc_ctrl_pkg::ADDR_CSR_A);

   // ----------------------------------------------------------------
   // Prescaler.
   // ----------------------------------------------------------------

   // Terminal count; codes 0 and 1 both divide by two.
   always_comb
   begin
      unique case (csr_a_q[2:0])
         3'h0, 3'h1: div_limit = 7'h01;             // RULE3
         3'h2:       div_limit = 7'h03;
         3'h3:       div_limit = 7'h07;
         3'h4:       div_limit = 7'h0f;
         3'h5:       div_limit = 7'h1f;
         3'h6:       div_limit = 7'h3f;
         3'h7:       div_limit = 7'h7f;
      endcase
   end

   // Free-running divider, held in reset while the converter is off.
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         div_q <= 7'h00;
      else if (!csr_a_q[adc_ctrl_pkg::BIT_CONVERTER_ON] || div_q >= div_limit)
         div_q <= 7'h00;
      else
         div_q <= div_q + 7'h01;
   end

   assign tick = csr_a_q[adc_ctrl_pkg::BIT_CONVERTER_ON] && (div_q >= div_limit); // RULE3

   // ----------------------------------------------------------------
   // Trigger selection.
   // ----------------------------------------------------------------

   // Pick the flag named by the trigger source field.
   always_comb
   begin
      unique case (csr_b_q[2:0])                     // RULE9
         3'h0: trig_sel = 1'b0;                      // RULE8
         3'h1: trig_sel = csr_b_q[adc_ctrl_pkg::BIT_CMP_PICK] ? TRIG.cmp1 : TRIG.cmp0; // RULE5
         3'h2: trig_sel = TRIG.ext_int0;
         3'h3: trig_sel = TRIG.t0_match;
         3'h4: trig_sel = TRIG.t0_ovf;
         3'h5: trig_sel = TRIG.t1_match_b;
         3'h6: trig_sel = TRIG.t1_ovf;
         3'h7: trig_sel = TRIG.t1_capture;
      endcase
   end

   // Remember the selected level so a source switch can make an edge.
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         trig_prev_q <= 1'b0;
      else
         trig_prev_q <= trig_sel;
   end

   // Edges count only with auto trigger on and not in continuous mode.
   assign trig_edge = csr_a_q[adc_ctrl_pkg::BIT_AUTO_TRIG]          // RULE6
                   && (csr_b_q[2:0] != adc_ctrl_pkg::TRIG_CONTINUOUS) // RULE8
                   && trig_sel && !trig_prev_q;                      // RULE7

   // A conversion starts on the start bit or a trigger edge.
   assign start_req = csr_a_q[adc_ctrl_pkg::BIT_CONVERTER_ON]        // RULE21
                   && (csr_a_q[adc_ctrl_pkg::BIT_START] || trig_edge); // RULE20

   // ----------------------------------------------------------------
   // Conversion sequencer.
   // ----------------------------------------------------------------

   // Walks idle, converting, done; counts converter clocks.
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         state_q    <= adc_ctrl_pkg::ST_IDLE;
         tick_cnt_q <= 4'h0;
      end
      else if (!csr_a_q[adc_ctrl_pkg::BIT_CONVERTER_ON])
      begin
         state_q    <= adc_ctrl_pkg::ST_IDLE;        // RULE21
         tick_cnt_q <= 4'h0;
      end
      else
      begin
         unique case (state_q)
            adc_ctrl_pkg::ST_IDLE:
            begin
               if (start_req)
               begin
                  state_q    <= adc_ctrl_pkg::ST_CONV;
                  tick_cnt_q <= 4'(adc_ctrl_pkg::CONV_TICKS);
               end
            end
            adc_ctrl_pkg::ST_CONV:
            begin
               if (tick && tick_cnt_q == 4'h1)
                  state_q <= adc_ctrl_pkg::ST_DONE;
               else if (tick)
                  tick_cnt_q <= tick_cnt_q - 4'h1;
            end
            adc_ctrl_pkg::ST_DONE:
               state_q <= adc_ctrl_pkg::ST_IDLE;
            default:
               state_q <= adc_ctrl_pkg::ST_IDLE;
         endcase
      end
   end

   assign finish = (state_q == adc_ctrl_pkg::ST_DONE);

   // ----------------------------------------------------------------
   // Result correction and alignment.
   // ----------------------------------------------------------------

   // Subtract the offset matching the half of the range in use.
   always_comb
   begin
      corrected = ANA_RESULT[11:0];
      if (csr_c_q[adc_ctrl_pkg::BIT_OFS_ON] && !csr_c_q[adc_ctrl_pkg::BIT_POL_FLIP]) // RULE19
      begin
         if (ANA_RESULT[11])
            corrected = ANA_RESULT[11:0] - {{4{ofs0_q[7]}}, ofs0_q};
         else
            corrected = ANA_RESULT[11:0] - {{4{ofs1_q[7]}}, ofs1_q};
      end
   end

   // Capture the result as the done flag rises.
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         result_q <= 12'h000;
      else if (finish)
         result_q <= corrected;                      // RULE23
   end

   // Reference latch: only follows software between conversions.
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         ref_q <= 3'h0;
      else if (state_q != adc_ctrl_pkg::ST_CONV)
         ref_q <= {csr_d_q[adc_ctrl_pkg::BIT_REF_MSB], mux_q[7:6]}; // RULE11
   end

   // ----------------------------------------------------------------
   // Control register A: start bit and done flag.
   // ----------------------------------------------------------------

   // Start bit self-clears at conversion end; done sets over clears.
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         csr_a_q <= adc_ctrl_pkg::RST_CSR_A;
      else
      begin
         if (wr_a)
         begin
            csr_a_q[7:5] <= WDATA[7:5];
            csr_a_q[3:0] <= WDATA[3:0];
         end
         // A write that turns the converter on and sets start together keeps the start.
         if (finish || (!csr_a_q[adc_ctrl_pkg::BIT_CONVERTER_ON] && !wr_a))
            csr_a_q[adc_ctrl_pkg::BIT_START] <= 1'b0;                 // RULE20
         else if (state_q == adc_ctrl_pkg::ST_CONV)
            csr_a_q[adc_ctrl_pkg::BIT_START] <= 1'b1;
         if (finish)
            csr_a_q[adc_ctrl_pkg::BIT_DONE] <= 1'b1; // RULE23
         else if ((wr_a && WDATA[adc_ctrl_pkg::BIT_DONE]) || IRQ_ACK)
            csr_a_q[adc_ctrl_pkg::BIT_DONE] <= 1'b0; // RULE1
      end
   end

   // ----------------------------------------------------------------
   // Remaining configuration registers.
   // ----------------------------------------------------------------

   // Plain read-write settings.
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         csr_b_q <= adc_ctrl_pkg::RST_ZERO;
         mux_q   <= adc_ctrl_pkg::RST_ZERO;
         csr_c_q <= adc_ctrl_pkg::RST_ZERO;
         csr_d_q <= adc_ctrl_pkg::RST_ZERO;
         dis0_q  <= adc_ctrl_pkg::RST_ZERO;
         dis1_q  <= adc_ctrl_pkg::RST_ZERO;
         ofs0_q  <= adc_ctrl_pkg::RST_ZERO;
         ofs1_q  <= adc_ctrl_pkg::RST_ZERO;
      end
      else if (WR)
      begin
         unique case (ADDR)
            adc_ctrl_pkg::ADDR_CSR_B: csr_b_q <= WDATA;
            adc_ctrl_pkg::ADDR_MUX:   mux_q   <= WDATA;
            adc_ctrl_pkg::ADDR_CSR_C: csr_c_q <= WDATA & adc_ctrl_pkg::MASK_CSR_C;
            adc_ctrl_pkg::ADDR_CSR_D: csr_d_q <= WDATA & adc_ctrl_pkg::MASK_CSR_D;
            adc_ctrl_pkg::ADDR_DIS_0: dis0_q  <= WDATA;
            adc_ctrl_pkg::ADDR_DIS_1: dis1_q  <= WDATA;
            adc_ctrl_pkg::ADDR_OFS_0: ofs0_q  <= WDATA;
            adc_ctrl_pkg::ADDR_OFS_1: ofs1_q  <= WDATA;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read port: data one cycle after the strobe.
   // ----------------------------------------------------------------

   // Unmapped addresses read as zero.
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         RDATA <= 8'h00;
      else if (RD)
      begin
         unique case (ADDR)
            adc_ctrl_pkg::ADDR_DATA_LO:
               RDATA <= mux_q[adc_ctrl_pkg::BIT_LEFT_ALIGN] ? {result_q[3:0], 4'h0} // RULE22
                                                           : result_q[7:0];         // RULE12
            adc_ctrl_pkg::ADDR_DATA_HI:
               RDATA <= mux_q[adc_ctrl_pkg::BIT_LEFT_ALIGN] ? result_q[11:4]
                                                           : {4'h0, result_q[11:8]}; // RULE12
            adc_ctrl_pkg::ADDR_CSR_A: RDATA <= csr_a_q;
            adc_ctrl_pkg::ADDR_CSR_B: RDATA <= csr_b_q;
            adc_ctrl_pkg::ADDR_MUX:   RDATA <= mux_q;
            adc_ctrl_pkg::ADDR_CSR_C: RDATA <= csr_c_q;
            adc_ctrl_pkg::ADDR_CSR_D: RDATA <= csr_d_q;
            adc_ctrl_pkg::ADDR_DIS_0: RDATA <= dis0_q;
            adc_ctrl_pkg::ADDR_DIS_1: RDATA <= dis1_q;
            adc_ctrl_pkg::ADDR_OFS_0: RDATA <= ofs0_q;
            adc_ctrl_pkg::ADDR_OFS_1: RDATA <= ofs1_q;
            default:                  RDATA <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Outputs to the core, pins and interrupt system.
   // ----------------------------------------------------------------
   assign IRQ_REQ = csr_a_q[adc_ctrl_pkg::BIT_DONE] && csr_a_q[adc_ctrl_pkg::BIT_IRQ_EN]
                 && GLOBAL_IRQ_EN;                   // RULE2
   assign ANA_ENABLE = csr_a_q[adc_ctrl_pkg::BIT_CONVERTER_ON]; // RULE21
   assign ANA_SAMPLE = (state_q == adc_ctrl_pkg::ST_CONV);
   assign ANA_TICK   = tick;
   assign ANA_CFG.reference = ref_q;                 // RULE10
   assign ANA_CFG.channel   = mux_q[4:0];            // RULE13
   assign ANA_CFG.pol_flip  = csr_c_q[adc_ctrl_pkg::BIT_POL_FLIP];  // RULE14
   assign ANA_CFG.fast      = csr_c_q[adc_ctrl_pkg::BIT_FAST];      // RULE15
   assign ANA_CFG.diff_path = csr_c_q[adc_ctrl_pkg::BIT_DIFF_PATH]; // RULE16
   assign ANA_CFG.ref_test  = csr_c_q[adc_ctrl_pkg::BIT_REF_TEST];  // RULE17
   assign ANA_CFG.cmp0_neg  = csr_b_q[7:6];          // RULE4
   assign ANA_CFG.cmp1_neg  = csr_b_q[5:4];          // RULE4
   assign PIN_DIG_IN_OFF    = {dis1_q, dis0_q};      // RULE18

   // ----------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   chk_done_sets: assert property (finish |=> csr_a_q[adc_ctrl_pkg::BIT_DONE]) // RULE23
      else $error("Done flag did not set at conversion end.");
   chk_done_clear: assert property (wr_a && WDATA[4] && !finish |=> !csr_a_q[4]) // RULE1
      else $error("Write one did not clear done flag.");
   chk_irq_gate: assert property (IRQ_REQ |-> csr_a_q[3] && GLOBAL_IRQ_EN) // RULE2
      else $error("Interrupt raised without enables.");
   chk_trig_gated: assert property (!csr_a_q[5] |-> !trig_edge) // RULE6
      else $error("Trigger edge counted with auto trigger off.");
   chk_cont_mode: assert property (csr_b_q[2:0] == 3'h0 |-> !trig_edge) // RULE8
      else $error("Edge trigger active in continuous mode.");
   chk_edge_start: assert property (trig_edge && csr_a_q[7] && state_q == adc_ctrl_pkg::ST_IDLE // RULE7
      |=> state_q == adc_ctrl_pkg::ST_CONV)
      else $error("Trigger edge did not start conversion.");
   chk_ref_hold: assert property (state_q == adc_ctrl_pkg::ST_CONV && $past(state_q) == adc_ctrl_pkg::ST_CONV // RULE11
      |-> $stable(ref_q))
      else $error("Reference changed mid conversion.");
   chk_off_idle: assert property (!csr_a_q[7] |=> state_q == adc_ctrl_pkg::ST_IDLE) // RULE21
      else $error("Conversion ran while disabled.");
   // The divide-by-two spacing is only owed while the code stays at zero or one.
   chk_div_two: assert property (tick && csr_a_q[7] && csr_a_q[2:1] == 2'b00 // RULE3
      ##1 csr_a_q[7] && csr_a_q[2:1] == 2'b00
      |-> !tick ##1 (tick || !csr_a_q[7] || csr_a_q[2:1] != 2'b00))
      else $error("Divide by two wrong.");
   chk_left_lo: assert property (RD && ADDR == adc_ctrl_pkg::ADDR_DATA_LO && mux_q[5] // RULE22
      && !WR |=> RDATA[3:0] == 4'h0)
      else $error("Left aligned low nibble not zero.");

   cov_single: cover property (csr_a_q[6] && state_q == adc_ctrl_pkg::ST_IDLE ##1 state_q == adc_ctrl_pkg::ST_CONV);
   cov_trigger: cover property (trig_edge && start_req);
   cov_done_irq: cover property (finish ##1 IRQ_REQ);

endmodule : adc_control_logic

`default_nettype wire

// ### testbench/adc_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------
// Converter core stand-in.
// -----------------------------------------------------------------
module adc_core_model
   #(
      parameter int TICKS = 15
   )
   (
      // Clock and control from the block.
      input  wire logic        clk,
      input  wire logic        sample,
      input  wire logic        tick,
      // Value that the bench wants converted.
      input  wire logic [11:0] value,
      // Result toward the block.
      output logic      [11:0] result
   );
   int   n_q;       // Ticks seen in the running conversion.
   logic sample_q;  // Sample level one cycle ago.

   // A new conversion restarts the count, so a short conversion is never mistaken for a full one.
   always_ff @(posedge clk)
   begin
      sample_q <= sample;
      if (sample && !sample_q)
         n_q <= int'(tick);
      else if (sample && tick)
         n_q <= n_q + 1;
   end

   // Until a full conversion is done the output shows the inverse, never a usable value.
   assign result = (n_q >= TICKS) ? value : ~value;
endmodule // adc_core_model

`default_nettype wire

// ### testbench/adc_control_logic_bench.sv
`timescale 1ns/1ps
`default_nettype none

// Counts a comparison and reports a mismatch at once.
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; $display("Error %s exp %0h got %0h", nm, e, g); end end

module adc_control_logic_bench;
   // ---------------------------------------------------------------
   // Stimulus and observed signals.
   // ---------------------------------------------------------------
   logic                      clk = 1'b0;
   logic                      rst = 1'b1;
   logic                      wr = 1'b0;
   logic                      rd = 1'b0;
   logic                      gie = 1'b0;
   logic                      ack = 1'b0;
   logic [7:0]                addr = 8'h00;
   logic [7:0]                wdata = 8'h00;
   logic [7:0]                rdata;
   adc_ctrl_pkg::trig_in_t    trig = '0;
   adc_ctrl_pkg::analog_cfg_t cfg;
   logic                      en;
   logic                      smp;
   logic                      tck;
   logic                      irq;
   logic [11:0]               val = 12'h000;
   logic [11:0]               res;
   logic [15:0]               pins;
   int                        fails = 0;
   int                        n_compared = 0;
   logic [7:0]                ra [8] = '{8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h7f, 8'had, 8'h80};

   // The core clock, 5 ns period.
   always #2.5 clk = ~clk;

   adc_control_logic #(.DATA_BITS(12)) DUT (
      .CORE_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .GLOBAL_IRQ_EN(gie), .IRQ_ACK(ack), .IRQ_REQ(irq), .TRIG(trig), .ANA_CFG(cfg),
      .ANA_ENABLE(en), .ANA_SAMPLE(smp), .ANA_TICK(tck), .ANA_RESULT(res), .PIN_DIG_IN_OFF(pins));

   adc_core_model #(.TICKS(15)) core (.clk(clk), .sample(smp), .tick(tck), .value(val), .result(res));

   // ---------------------------------------------------------------
   // Bus and helper tasks.
   // ---------------------------------------------------------------
   // One-cycle register write.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // One-cycle read; the data are looked at in the following cycle only.
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      @(negedge clk);
      `CHK($sformatf("read %h", a), e, rdata)
   endtask

   // One-cycle pulse on a trigger flag.
   task automatic pulse(input int i);
      @(posedge clk);
      trig[i] <= 1'b1;
      @(posedge clk);
      trig[i] <= 1'b0;
   endtask

   // Checks whether a conversion starts, optionally the tick spacing, then waits for its end.
   task automatic conv(input logic s, input int g);
      int k;
      @(negedge clk);
      for (k = 0; k < 8 && smp !== 1'b1; k++) @(negedge clk);
      `CHK("sample", s, smp)
      if (g > 0)
      begin
         for (k = 0; k < 300 && tck !== 1'b1; k++) @(negedge clk);
         @(negedge clk);
         for (k = 1; k < 300 && tck !== 1'b1; k++) @(negedge clk);
         `CHK("tick gap", g, k)
      end
      for (k = 0; k < 9000 && smp === 1'b1; k++) @(negedge clk);
      `CHK("conv end", 1'b0, smp)
      repeat (3) @(posedge clk);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Test sequence.
   // ---------------------------------------------------------------
   initial
   begin
      logic [7:0] b;
      int         r;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++)
         rd_chk(ra[i], (i == 0) ? 8'h05 : 8'h00);
      wr_reg(8'h7b, 8'h60);
      wr_reg(8'h7c, 8'h3f);
      wr_reg(8'had, 8'h40);
      wr_reg(8'h7d, 8'h27);
      wr_reg(8'h7e, 8'ha5);
      wr_reg(8'h7f, 8'h3c);
      rd_chk(8'h7d, 8'h27);
      `CHK("cmp neg", 4'h6, {cfg.cmp0_neg, cfg.cmp1_neg})
      `CHK("reference", 3'h4, cfg.reference)
      `CHK("channel", 5'h1f, cfg.channel)
      `CHK("modes", 4'hf, {cfg.pol_flip, cfg.fast, cfg.diff_path, cfg.ref_test})
      `CHK("pins", 16'h3ca5, pins)
      wr_reg(8'h7d, 8'h00);
      wr_reg(8'had, 8'h00);
      wr_reg(8'h7c, 8'h00);
      val <= 12'habc;
      // Every divider code, each started by the start bit.
      for (int c = 0; c < 8; c++)
      begin
         wr_reg(8'h7a, 8'hd0 | c[7:0]);
         conv(1'b1, (c < 2) ? 2 : (1 << c));
      end
      gie <= 1'b1;
      rd_chk(8'h7a, 8'h97);
      `CHK("enable", 1'b1, en)
      `CHK("irq", 1'b0, irq)
      rd_chk(8'h78, 8'hbc);
      rd_chk(8'h79, 8'h0a);
      wr_reg(8'h7a, 8'hc8);
      conv(1'b1, 0);
      @(negedge clk);
      `CHK("irq", 1'b1, irq)
      @(posedge clk);
      gie <= 1'b0;
      @(negedge clk);
      `CHK("irq", 1'b0, irq)
      @(posedge clk);
      gie <= 1'b1;
      wr_reg(8'h7a, 8'h98);
      @(negedge clk);
      `CHK("irq", 1'b0, irq)
      wr_reg(8'h7c, 8'h20);
      wr_reg(8'h7a, 8'hc8);
      conv(1'b1, 0);
      rd_chk(8'h78, 8'hc0);
      rd_chk(8'h79, 8'hab);
      `CHK("irq", 1'b1, irq)
      @(posedge clk);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      @(negedge clk);
      `CHK("irq", 1'b0, irq)
      rd_chk(8'h7a, 8'h88);
      // A reference change in mid-conversion waits for its end.
      wr_reg(8'h7c, 8'h00);
      wr_reg(8'h7a, 8'hc0);
      wr_reg(8'h7c, 8'h40);
      @(negedge clk);
      `CHK("ref held", 3'h0, cfg.reference)
      conv(1'b1, 0);
      @(negedge clk);
      `CHK("ref new", 3'h1, cfg.reference)
      // Offset correction on a result with a clear top bit.
      wr_reg(8'ha4, 8'h05);
      wr_reg(8'h7d, 8'h80);
      val <= 12'h123;
      wr_reg(8'h7a, 8'hd0);
      conv(1'b1, 0);
      rd_chk(8'h78, 8'h1e);
      rd_chk(8'h79, 8'h01);
      // A set top bit takes the other offset, here minus two.
      wr_reg(8'ha3, 8'hfe);
      val <= 12'h923;
      wr_reg(8'h7a, 8'hd0);
      conv(1'b1, 0);
      rd_chk(8'h78, 8'h25);
      rd_chk(8'h79, 8'h09);
      // With the polarity flipped the raw result passes uncorrected.
      wr_reg(8'h7d, 8'ha0);
      wr_reg(8'h7a, 8'hd0);
      conv(1'b1, 0);
      rd_chk(8'h78, 8'h23);
      wr_reg(8'h7d, 8'h00);
      // Trigger sources: ignored without auto-trigger and in continuous mode.
      wr_reg(8'h7a, 8'h90);
      wr_reg(8'h7b, 8'h02);
      pulse(5);
      conv(1'b0, 0);
      wr_reg(8'h7a, 8'ha0);
      wr_reg(8'h7b, 8'h00);
      pulse(7);
      conv(1'b0, 0);
      // Each source: a neighbour's flag must not start, its own must.
      for (int c = 0; c < 8; c++)
      begin
         b = (c == 0) ? 8'h09 : c[7:0];
         r = (c == 0) ? 6 : (c == 1) ? 7 : 7 - c;
         wr_reg(8'h7b, b);
         pulse(r ^ 1);
         conv(1'b0, 0);
         pulse(r);
         conv(1'b1, 0);
         wr_reg(8'h7a, 8'hb0);
      end
      // Switching to a source whose flag already stands high.
      wr_reg(8'h7b, 8'h03);
      trig[2] <= 1'b1;
      wr_reg(8'h7b, 8'h05);
      conv(1'b1, 0);
      trig[2] <= 1'b0;
      close_out();
   end

   // Cuts a hang short well beyond the expected run length.
   initial
   begin
      #100_000;
      fails++;
      close_out();
   end
endmodule // adc_control_logic_bench

`default_nettype wire
